// ===== verilog/tsr_pkg.sv
// Constants for the temperature sensor register bank
`default_nettype none
package tsr_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int GLITCH_NS = 50;
  localparam int FILT_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_MS = 25;
  localparam int TOUT_CYC = (TOUT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_CYC = 8;
  // Widths
  localparam int IDX_W = 8;
  localparam int REG_W = 16;
  // Register indices
  localparam logic [7:0] IDX_CAP = 8'h00;
  localparam logic [7:0] IDX_CFG = 8'h01;
  localparam logic [7:0] IDX_UPPER = 8'h02;
  localparam logic [7:0] IDX_LOWER = 8'h03;
  localparam logic [7:0] IDX_CRIT = 8'h04;
  localparam logic [7:0] IDX_TEMP = 8'h05;
  localparam logic [7:0] IDX_MAKER = 8'h06;
  localparam logic [7:0] IDX_PART = 8'h07;
  localparam logic [7:0] IDX_BUSOPT = 8'h22;
  // Reset values
  localparam logic [15:0] CAP_RESET = 16'h0015;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [7:0] IDX_RESET = 8'h00;
  // Bus options field
  localparam int BUSOPT_TOUT_DIS = 7;
  // Address byte layout
  localparam logic [3:0] ADDR_HI_DEF = 4'h3;
  // Bus state machine
  typedef enum logic [3:0] {
    ST_POR, ST_LOAD, ST_IDLE, ST_ADDR, ST_AACK,
    ST_RX, ST_RACK, ST_TX, ST_MACK
  } tsr_state_t;
endpackage : tsr_pkg
`default_nettype wire

// ===== verilog/tsr_regbank.sv
// Pointer-addressed register bank behind a two-wire slave port
// Functional notes
// - Data and alert pins released during power-up
// - Filter bus input glitches up to 50 ns
// - Stay in reset while clock line low
// - Load defaults and calibration before operating
// - Pointer selects every data register
// - Write-only register reads return zero
// - Read-only writes acked, contents unchanged
// - Eight-bit pointer, sixteen-bit data registers
// - Capability resets to 0015h
// - Configuration and upper limit reset zero
// - Lower and critical limits reset zero
// - Temperature at 05h from conversion
// - Fixed maker and part codes, unwritable
// - Reserved read zero; bus options reset zero
// - Pointer keeps last written index
// - Timeout enabled after reset, bit7 disables
`default_nettype none
module tsr_regbank
  import tsr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a5a, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h0b01, // arbitrary value
  parameter logic [3:0] ADDR_HI = ADDR_HI_DEF,
  parameter int TOUT_LIMIT = TOUT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Alert pin
  output logic event_o,
  output logic event_oe_n,
  // Address straps
  input wire logic [2:0] addr_i,
  // Conversion side
  input wire logic [15:0] temp_i,
  output logic [15:0] cfg,
  output logic [15:0] upper_limit,
  output logic [15:0] lower_limit,
  output logic [15:0] crit_limit,
  output logic ready
);

  tsr_state_t st;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_f;
  logic [1:0] flt_cnt [2];
  logic [2:0] addr_s1;
  logic [2:0] addr_s2;
  logic scl_d;
  logic sda_d;
  logic scl_f;
  logic sda_f;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic rw;
  logic [1:0] byte_n;
  logic [7:0] wr_hi;
  logic [15:0] rd_word;
  logic hi_sel;
  logic drv_low;
  logic [7:0] ptr;
  logic [15:0] cap;
  logic [15:0] maker;
  logic [15:0] part;
  logic [15:0] temp;
  logic [15:0] busopt;
  logic [2:0] load_cnt;
  logic [23:0] tout_cnt;
  logic tout_hit;
  logic wr_commit;
  logic [15:0] next_rd;

  function automatic logic is_writable(input logic [7:0] idx);
    case (idx)
      IDX_CFG, IDX_UPPER, IDX_LOWER, IDX_CRIT, IDX_BUSOPT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_writable

  // Two-flop synchronisers for pins and straps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
    end else begin
      pin_s1 <= {sda_i, scl_i};
      pin_s2 <= pin_s1;
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
    end
  end

  // Noise filter: change accepted after FILT_CYC+1 stable samples
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_f <= 2'h0;
      flt_cnt[0] <= 2'h0;
      flt_cnt[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_s2[i] == pin_f[i]) begin
          flt_cnt[i] <= 2'h0;
        end else if (flt_cnt[i] == 2'(FILT_CYC)) begin
          pin_f[i] <= pin_s2[i];
          flt_cnt[i] <= 2'h0;
        end else begin
          flt_cnt[i] <= flt_cnt[i] + 2'h1;
        end
      end
    end
  end

  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];

  // Edge history of filtered lines
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b0;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign start_det = scl_f && scl_d && sda_d && !sda_f;
  assign stop_det = scl_f && scl_d && !sda_d && sda_f;
  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;

  // Bus timeout counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tout_cnt <= 24'h0;
    end else if (scl_f || st == ST_IDLE || st == ST_POR || st == ST_LOAD) begin
      tout_cnt <= 24'h0;
    end else if (!tout_hit) begin
      tout_cnt <= tout_cnt + 24'h1;
    end
  end

  assign tout_hit = !busopt[BUSOPT_TOUT_DIS] &&
                    tout_cnt >= 24'(TOUT_LIMIT - 1);

  // Read data selection
  always_comb begin
    case (ptr)
      IDX_CAP: next_rd = cap;
      IDX_CFG: next_rd = cfg;
      IDX_UPPER: next_rd = upper_limit;
      IDX_LOWER: next_rd = lower_limit;
      IDX_CRIT: next_rd = crit_limit;
      IDX_TEMP: next_rd = temp;
      IDX_MAKER: next_rd = maker;
      IDX_PART: next_rd = part;
      IDX_BUSOPT: next_rd = busopt;
      default: next_rd = ZERO_RESET;
    endcase
  end

  assign wr_commit = (st == ST_RX) && scl_fall && bit_cnt == 4'h8 &&
                     byte_n == 2'h2;

  // Protocol state machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= ST_POR;
      load_cnt <= 3'h0;
      bit_cnt <= 4'h0;
      sh <= 8'h0;
      tx <= 8'h0;
      rw <= 1'b0;
      byte_n <= 2'h0;
      wr_hi <= 8'h0;
      rd_word <= 16'h0;
      hi_sel <= 1'b0;
      drv_low <= 1'b0;
      ptr <= IDX_RESET;
    end else if (st == ST_POR) begin
      drv_low <= 1'b0;
      if (scl_f) begin
        st <= ST_LOAD;
      end
    end else if (st == ST_LOAD) begin
      load_cnt <= load_cnt + 3'h1;
      if (load_cnt == 3'(LOAD_CYC - 1)) begin
        st <= ST_IDLE;
      end
    end else if (stop_det || tout_hit) begin
      st <= ST_IDLE;
      drv_low <= 1'b0;
    end else if (start_det) begin
      st <= ST_ADDR;
      bit_cnt <= 4'h0;
      drv_low <= 1'b0;
    end else begin
      case (st)
        ST_ADDR: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (sh[7:1] == {ADDR_HI, addr_s2}) begin
              drv_low <= 1'b1;
              rw <= sh[0];
              st <= ST_AACK;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw) begin
              rd_word <= next_rd;
              drv_low <= ~next_rd[15];
              tx <= {next_rd[14:8], 1'b0};
              hi_sel <= 1'b0;
              bit_cnt <= 4'h1;
              st <= ST_TX;
            end else begin
              drv_low <= 1'b0;
              byte_n <= 2'h0;
              st <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            drv_low <= 1'b1;
            bit_cnt <= 4'h0;
            st <= ST_RACK;
            if (byte_n == 2'h0) begin
              ptr <= sh;
            end else if (byte_n == 2'h1) begin
              wr_hi <= sh;
            end
            if (byte_n != 2'h3) begin
              byte_n <= byte_n + 2'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            drv_low <= 1'b0;
            st <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              drv_low <= 1'b0;
              st <= ST_MACK;
            end else begin
              drv_low <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_f) begin
            st <= ST_IDLE;
          end else if (scl_fall) begin
            hi_sel <= ~hi_sel;
            bit_cnt <= 4'h1;
            st <= ST_TX;
            if (!hi_sel) begin
              drv_low <= ~rd_word[7];
              tx <= {rd_word[6:0], 1'b0};
            end else begin
              drv_low <= ~rd_word[15];
              tx <= {rd_word[14:8], 1'b0};
            end
          end
        end
        default: begin
          drv_low <= 1'b0;
        end
      endcase
    end
  end

  // Operational registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap <= ZERO_RESET;
      maker <= ZERO_RESET;
      part <= ZERO_RESET;
      cfg <= ZERO_RESET;
      upper_limit <= ZERO_RESET;
      lower_limit <= ZERO_RESET;
      crit_limit <= ZERO_RESET;
      busopt <= ZERO_RESET;
    end else if (st == ST_LOAD) begin
      cap <= CAP_RESET;
      maker <= MAKER_ID;
      part <= PART_ID;
      cfg <= ZERO_RESET;
      upper_limit <= ZERO_RESET;
      lower_limit <= ZERO_RESET;
      crit_limit <= ZERO_RESET;
      busopt <= ZERO_RESET;
    end else if (wr_commit && is_writable(ptr)) begin
      case (ptr)
        IDX_CFG: cfg <= {wr_hi, sh};
        IDX_UPPER: upper_limit <= {wr_hi, sh};
        IDX_LOWER: lower_limit <= {wr_hi, sh};
        IDX_CRIT: crit_limit <= {wr_hi, sh};
        IDX_BUSOPT: busopt <= {wr_hi, sh};
        default: cfg <= cfg;
      endcase
    end
  end

  // Temperature capture from conversion logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      temp <= ZERO_RESET;
    end else begin
      temp <= temp_i;
    end
  end

  // Pin drivers, released during reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_o <= 1'b0;
      sda_oe_n <= 1'b1;
      event_o <= 1'b0;
      event_oe_n <= 1'b1;
      ready <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= ~drv_low;
      event_o <= 1'b0;
      event_oe_n <= 1'b1;
      ready <= st != ST_POR && st != ST_LOAD;
    end
  end

endmodule : tsr_regbank
`default_nettype wire

// ===== verif/tsr_chk.sv
// Port checker for the register bank
`default_nettype none
module tsr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic event_oe_n,
  // Registers and status
  input wire logic [15:0] cfg,
  input wire logic [15:0] upper_limit,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hi_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Clock-high cycles since reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      hi_cnt <= 4'h0;
    else if (scl_i && hi_cnt != 4'hf)
      hi_cnt <= hi_cnt + 4'h1;
  end
  sequence s_high;
    scl_i [*7];
  endsequence
  sequence s_por;
    (!ready && scl_i) [*8];
  endsequence
  property p_rel;
    !ready |-> sda_oe_n && event_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("pin driven in POR");
  property p_od;
    event_oe_n && !sda_o;
  endproperty
  a_od: assert property (p_od) else $error("pin levels wrong");
  property p_hold;
    s_high |-> $stable(sda_oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_leave;
    s_por |-> ##[0:12] ready;
  endproperty
  a_leave: assert property (p_leave) else $error("stuck in POR");
  property p_scl;
    $rose(ready) |-> hi_cnt >= 4'h3;
  endproperty
  a_scl: assert property (p_scl) else $error("left POR early");
  property p_stay;
    ready |=> ready;
  endproperty
  a_stay: assert property (p_stay) else $error("ready dropped");
  property p_zero;
    !ready |-> cfg == 16'h0000 && upper_limit == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("bad reset");
  property p_wlow;
    $changed({cfg, upper_limit}) |-> !scl_i && ready;
  endproperty
  a_wlow: assert property (p_wlow) else $error("bad commit");
endmodule : tsr_chk
bind tsr_regbank tsr_chk u_chk (.mclk, .rstn, .scl_i, .sda_o, .sda_oe_n,
  .event_oe_n, .cfg, .upper_limit, .ready);
`default_nettype wire

// ===== verif/tsr_host.sv
// Bus host model for the register bank
`default_nettype none
module tsr_host #(
  parameter logic [6:0] DEV = 7'h00
) (
  // Clock
  input wire logic mclk,
  // Bus
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w
  task automatic hold_low(input int n);
    scl = 1'b0;
    w(n);
    scl = 1'b1;
  endtask : hold_low
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    w(10);
    scl = 1'b1;
    w(10);
    r = sda;
    scl = 1'b0;
    w(3);
  endtask : bit_io
  task automatic start;
    sda_m = 1'b1;
    w(10);
    scl = 1'b1;
    w(10);
    sda_m = 1'b0;
    w(10);
    scl = 1'b0;
    w(3);
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    w(10);
    scl = 1'b1;
    w(10);
    sda_m = 1'b1;
    w(10);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask : xfer
  // Address, index, then an optional word
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input logic full, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    start;
    xfer({DEV, 1'b0}, 1'b1, rx, a0);
    xfer(idx, 1'b1, rx, a1);
    ok = !a0 && !a1;
    if (full) begin
      xfer(d[15:8], 1'b1, rx, a0);
      xfer(d[7:0], 1'b1, rx, a1);
      ok = ok && !a0 && !a1;
    end
    stop;
  endtask : wr
  // Word read at the held index, up to four tries until answered
  task automatic rd(output logic [15:0] d, output logic ok);
    logic a;
    ok = 1'b0;
    d = 16'h0000;
    for (int k = 0; k < 4 && !ok; k++) begin
      start;
      xfer({DEV, 1'b1}, 1'b1, d[15:8], a);
      ok = !a;
      if (ok) begin
        xfer(8'hff, 1'b0, d[15:8], a);
        xfer(8'hff, 1'b1, d[7:0], a);
      end
      stop;
    end
  endtask : rd
endmodule : tsr_host
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the register bank
`default_nettype none
module tb_top import tsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MID = 16'h3c3c; // arbitrary value
  localparam logic [15:0] PID = 16'h0d02; // arbitrary value
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ok;
  logic [15:0] temp_i = 16'h0000;
  logic [15:0] rnd, d, ev [1:4];
  logic [7:0] ri [11] = '{8'h01, 8'h02, 8'h03, 8'h04, IDX_MAKER, IDX_PART,
    8'h08, 8'h21, IDX_BUSOPT, 8'h23, 8'hff};
  logic [7:0] ro [5] = '{IDX_CAP, IDX_TEMP, IDX_MAKER, IDX_PART, 8'h30};
  wire logic scl, sda_m, sda_o, sda_oe_n, event_o, event_oe_n, ready;
  wire logic [15:0] cfg, upper_limit, lower_limit, crit_limit;
  wire logic sda = sda_m & (sda_oe_n | sda_o);
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  tsr_regbank #(.MAKER_ID(MID), .PART_ID(PID), .TOUT_LIMIT(200)) DUT (
    .mclk, .rstn, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n, .event_o,
    .event_oe_n, .addr_i(3'h5), .temp_i, .cfg, .upper_limit, .lower_limit,
    .crit_limit, .ready);
  tsr_host #(.DEV({ADDR_HI_DEF, 3'h5})) host (.mclk, .scl, .sda_m, .sda);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] rst_val(input logic [7:0] i);
    case (i)
      IDX_CAP: return CAP_RESET;
      IDX_MAKER: return MID;
      IDX_PART: return PID;
      default: return ZERO_RESET;
    endcase
  endfunction : rst_val
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, input logic e);
    chk_w({15'h0000, g}, {15'h0000, e});
  endtask : chk_b
  task automatic rd_at(input logic [7:0] i, output logic [15:0] v);
    host.wr(i, 16'h0000, 1'b0, ok);
    host.rd(v, ok);
  endtask : rd_at
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    rnd = 16'hfacf;
    @(posedge mclk);
    #1;
    fork
      begin
        host.hold_low(30);
        host.w(1);
        host.hold_low(39);
      end
      begin
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (50) @(posedge mclk);
        #1;
        chk_b(ready, 1'b0);
        chk_b(sda_oe_n, 1'b1);
        chk_b(event_oe_n && !event_o, 1'b1);
      end
    join
    host.rd(d, ok);
    chk_b(ok, 1'b1);
    chk_w(d, CAP_RESET);
    foreach (ri[k]) begin
      rd_at(ri[k], d);
      chk_w(d, rst_val(ri[k]));
    end
    foreach (ro[k]) begin
      rnd = lfsr(rnd);
      temp_i = rnd;
      host.wr(ro[k], ~rnd, 1'b1, ok);
      chk_b(ok, 1'b1);
      rd_at(ro[k], d);
      chk_w(d, ro[k] == IDX_TEMP ? rnd : rst_val(ro[k]));
    end
    for (int k = 1; k <= 4; k++) begin
      rnd = lfsr(rnd);
      ev[k] = k == 4 ? 16'hffff : rnd;
      host.wr(8'(k), ev[k], 1'b1, ok);
    end
    for (int k = 1; k <= 4; k++) begin
      rd_at(8'(k), d);
      chk_w(d, ev[k]);
    end
    host.rd(d, ok);
    chk_w(d, ev[4]);
    chk_w(cfg, ev[1]);
    chk_w(upper_limit, ev[2]);
    chk_w(lower_limit, ev[3]);
    chk_w(crit_limit, ev[4]);
    for (int k = 0; k < 2; k++) begin
      host.wr(IDX_BUSOPT, {8'h00, k[0], 7'h00}, 1'b1, ok);
      host.wr(IDX_CAP, 16'h0000, 1'b0, ok);
      host.start;
      host.xfer({ADDR_HI_DEF, 3'h5, 1'b1}, 1'b1, d[7:0], ok);
      host.w(300);
      chk_b(sda_oe_n, !k[0]);
      host.xfer(8'hff, 1'b1, d[7:0], ok);
      host.stop;
    end
    rstn = 1'b0;
    @(posedge mclk);
    #1 rstn = 1'b1;
    chk_w(cfg, ZERO_RESET);
    host.rd(d, ok);
    chk_w(d, CAP_RESET);
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
